// ### design/pllc_top.sv
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module pllc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic loop_locked,
  input wire logic loop_tracking,
  input wire logic vco_clock,
  input wire logic crystal_clock,
  output logic pll_enable,
  output logic osc_enable,
  output logic base_clock_select,
  output logic base_clock_output,
  output logic pll_irq_req
);
  pllc_pkg::pllc_req_type req;
  pllc_pkg::pllc_loop_type loop;
  logic pll_irq_enable_r;
  logic pll_change_flag_r;
  logic pll_power_on_r;
  logic base_clock_select_r;
  logic auto_r;
  logic trk_manual_r;
  logic break_clear_enable_r;
  logic in_break_r;
  logic in_wait_r;
  logic in_stop_r;
  logic [pllc_pkg::PLLC_EV_W-1:0] stat_r;
  logic [pllc_pkg::PLLC_EV_W-1:0] mask_r;
  logic [pllc_pkg::PLLC_EV_W-1:0] ev;
  logic ack_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic irq_r;
  logic pll_irq_req_r;
  logic pll_enable_r;
  logic osc_enable_r;
  logic bco_r;
  logic div_x_r;
  logic div_v_r;
  logic lock_rise;
  logic lock_fall;
  logic trk_rise;
  logic sw_busy;
  logic sw_done;
  logic sel_eff;
  logic ctrl_rd;
  logic ctrl_wr;
  logic flag_clr;
  logic [7:0] ctrl_val;
  logic [7:0] bw_val;

  function automatic logic hit(input pllc_pkg::pllc_req_type r, input logic [3:0] a);
    hit = (r.read | r.write) && (r.address == a);
  endfunction : hit

  assign req = '{read: read, write: write, address: address, writedata: writedata};
  assign loop = '{lock: loop_locked, trk: loop_tracking};

  pllc_edge lock_det (
    .clk(clk),
    .resetn(resetn),
    .sig(loop.lock),
    .rise(lock_rise),
    .fall(lock_fall)
  );

  pllc_edge trk_det (
    .clk(clk),
    .resetn(resetn),
    .sig(loop.trk),
    .rise(trk_rise),
    .fall()
  );

  pllc_switch sw (
    .clk(clk),
    .resetn(resetn),
    .sel(base_clock_select_r),
    .stop(in_stop_r),
    .busy(sw_busy),
    .done(sw_done),
    .sel_eff(sel_eff)
  );

  // Access completes when ack_r is high, one wait state on every access
  assign ctrl_rd = req.read && hit(req, pllc_pkg::PLLC_ADDR_CTRL) && ack_r;
  assign ctrl_wr = req.write && hit(req, pllc_pkg::PLLC_ADDR_CTRL) && ack_r;
  // Break protects the flag unless clear is allowed
  assign flag_clr = ctrl_rd && (!in_break_r || break_clear_enable_r);

  logic lock_s_r;
  logic trk_s_r;
  function automatic logic loop_lock_q();
    loop_lock_q = lock_s_r & auto_r;
  endfunction : loop_lock_q
  function automatic logic trk_q();
    trk_q = trk_s_r;
  endfunction : trk_q

  // Lock only has meaning in auto mode; outside it the tracking bit reads back trk_manual_r
  always_comb begin
    ctrl_val = {pll_irq_enable_r & auto_r, pll_change_flag_r & auto_r,
                pll_power_on_r, base_clock_select_r, pllc_pkg::PLLC_CTRL_UNUSED};
    bw_val = {auto_r, loop_lock_q(), auto_r ? trk_q() : trk_manual_r, 5'h00};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_s_r <= 1'b0;
      trk_s_r <= 1'b0;
    end else begin
      if (lock_rise) lock_s_r <= 1'b1;
      else if (lock_fall) lock_s_r <= 1'b0;
      if (trk_rise) trk_s_r <= 1'b1;
      else if (lock_fall && !loop.trk) trk_s_r <= 1'b0;
    end
  end

  // Bus handshake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      waitrequest_r <= 1'b1;
    end else begin
      ack_r <= (req.read | req.write) && !ack_r;
      // Own flop so the bus never sees an inverter glitch
      waitrequest_r <= !((req.read | req.write) && !ack_r);
    end
  end
  assign waitrequest = waitrequest_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata_r <= 32'h0000_0000;
    end else if (req.read && !ack_r) begin
      case (req.address)
        pllc_pkg::PLLC_ADDR_CTRL: readdata_r <= {24'h000000, ctrl_val};
        pllc_pkg::PLLC_ADDR_BW: readdata_r <= {24'h000000, bw_val};
        pllc_pkg::PLLC_ADDR_STAT: readdata_r <= {28'h0000000, stat_r};
        pllc_pkg::PLLC_ADDR_MASK: readdata_r <= {28'h0000000, mask_r};
        pllc_pkg::PLLC_ADDR_SYS: readdata_r <= {28'h0000000, in_stop_r, in_wait_r,
                                               in_break_r, break_clear_enable_r};
        default: readdata_r <= pllc_pkg::PLLC_RDATA_BAD;
      endcase
    end
  end
  assign readdata = readdata_r;

  // Control register with select and power interlock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_irq_enable_r <= 1'b0;
      pll_power_on_r <= pllc_pkg::PLLC_ON_RST;
      base_clock_select_r <= 1'b0;
    end else if (ctrl_wr) begin
      if (auto_r) pll_irq_enable_r <= req.writedata[pllc_pkg::PLLC_CTRL_IE];
      // Select needs power on already; lock is not checked
      base_clock_select_r <= req.writedata[pllc_pkg::PLLC_CTRL_BCS]
                             & pll_power_on_r;
      pll_power_on_r <= req.writedata[pllc_pkg::PLLC_CTRL_ON]
                        | base_clock_select_r;
    end
  end

  // Change flag, set wins over a read clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_change_flag_r <= 1'b0;
    end else if (auto_r && (lock_rise || lock_fall)) begin
      pll_change_flag_r <= 1'b1;
    end else if (flag_clr) begin
      pll_change_flag_r <= 1'b0;
    end
  end

  // Bandwidth and system control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_r <= 1'b0;
      trk_manual_r <= 1'b0;
      break_clear_enable_r <= 1'b0;
      in_break_r <= 1'b0;
      in_wait_r <= 1'b0;
      in_stop_r <= 1'b0;
      mask_r <= '0;
    end else if (req.write && ack_r) begin
      case (req.address)
        pllc_pkg::PLLC_ADDR_BW: begin
          auto_r <= req.writedata[pllc_pkg::PLLC_BW_AUTO];
          if (!auto_r) trk_manual_r <= req.writedata[pllc_pkg::PLLC_BW_TRK];
        end
        pllc_pkg::PLLC_ADDR_MASK: mask_r <= req.writedata[pllc_pkg::PLLC_EV_W-1:0];
        pllc_pkg::PLLC_ADDR_SYS: begin
          break_clear_enable_r <= req.writedata[pllc_pkg::PLLC_SYS_BREAK_CLEAR_ENABLE];
          in_break_r <= req.writedata[pllc_pkg::PLLC_SYS_BRK];
          in_wait_r <= req.writedata[pllc_pkg::PLLC_SYS_WAIT];
          in_stop_r <= req.writedata[pllc_pkg::PLLC_SYS_STOP];
        end
        default: ;
      endcase
    end
  end

  // Sticky event status, set beats write-one clear
  always_comb begin
    ev = '0;
    ev[pllc_pkg::PLLC_EV_LOCK_RISE] = auto_r & lock_rise;
    ev[pllc_pkg::PLLC_EV_LOCK_FALL] = auto_r & lock_fall;
    ev[pllc_pkg::PLLC_EV_TRK] = auto_r & trk_rise;
    ev[pllc_pkg::PLLC_EV_SWITCH] = sw_done;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= '0;
    end else if (req.write && ack_r && req.address == pllc_pkg::PLLC_ADDR_STAT) begin
      stat_r <= (stat_r & ~req.writedata[pllc_pkg::PLLC_EV_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
      pll_irq_req_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
      pll_irq_req_r <= auto_r & pll_irq_enable_r & pll_change_flag_r;
    end
  end
  assign irq = irq_r;
  assign pll_irq_req = pll_irq_req_r;

  // Wait changes nothing here; only stop gates the generator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_enable_r <= 1'b0;
      osc_enable_r <= 1'b0;
    end else begin
      pll_enable_r <= pll_power_on_r & ~in_stop_r;
      osc_enable_r <= ~in_stop_r;
    end
  end
  assign pll_enable = pll_enable_r;
  assign osc_enable = osc_enable_r;
  assign base_clock_select = sel_eff;

  // Divide-by-two of each source, sampled as synchronous inputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_x_r <= 1'b0;
      div_v_r <= 1'b0;
      bco_r <= 1'b0;
    end else if (in_stop_r) begin
      div_x_r <= 1'b0;
      div_v_r <= 1'b0;
      bco_r <= 1'b0;
    end else begin
      if (crystal_clock) div_x_r <= ~div_x_r;
      if (vco_clock) div_v_r <= ~div_v_r;
      if (!sw_busy) bco_r <= sel_eff ? div_v_r : div_x_r;
    end
  end
  assign base_clock_output = bco_r;
endmodule : pllc_top

// ### design/pllc_pkg.sv
package pllc_pkg;
  localparam logic [3:0] PLLC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] PLLC_ADDR_BW = 4'h1;
  localparam logic [3:0] PLLC_ADDR_STAT = 4'h2;
  localparam logic [3:0] PLLC_ADDR_MASK = 4'h3;
  localparam logic [3:0] PLLC_ADDR_SYS = 4'h4;
  // Control register fields
  localparam int PLLC_CTRL_IE = 7;
  localparam int PLLC_CTRL_FLAG = 6;
  localparam int PLLC_CTRL_ON = 5;
  localparam int PLLC_CTRL_BCS = 4;
  localparam logic [3:0] PLLC_CTRL_UNUSED = 4'hf;
  // Bandwidth register fields
  localparam int PLLC_BW_AUTO = 7;
  localparam int PLLC_BW_LOCK = 6;
  localparam int PLLC_BW_TRK = 5;
  // System register fields
  localparam int PLLC_SYS_BREAK_CLEAR_ENABLE = 0;
  localparam int PLLC_SYS_BRK = 1;
  localparam int PLLC_SYS_WAIT = 2;
  localparam int PLLC_SYS_STOP = 3;
  // Event status bits
  localparam int PLLC_EV_LOCK_RISE = 0;
  localparam int PLLC_EV_LOCK_FALL = 1;
  localparam int PLLC_EV_TRK = 2;
  localparam int PLLC_EV_SWITCH = 3;
  localparam int PLLC_EV_W = 4;
  localparam logic PLLC_ON_RST = 1'b1;
  localparam int PLLC_SWITCH_CYCLES = 3;
  localparam logic [31:0] PLLC_RDATA_BAD = 32'hdeadbeef;

  typedef struct packed {
    logic lock;
    logic trk;
  } pllc_loop_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } pllc_req_type;
endpackage : pllc_pkg

// ### design/pllc_edge.sv
`timescale 1ns/10ps
module pllc_edge (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sig,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic prev_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      s1_r <= sig;
      s2_r <= s1_r;
      prev_r <= s2_r;
    end
  end

  assign rise = s2_r & ~prev_r;
  assign fall = ~s2_r & prev_r;
endmodule : pllc_edge

// ### design/pllc_switch.sv
`timescale 1ns/10ps
module pllc_switch #(
  parameter int CYCLES = pllc_pkg::PLLC_SWITCH_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sel,
  input wire logic stop,
  output logic busy,
  output logic done,
  output logic sel_eff
);
  logic [3:0] cnt_r;
  logic sel_r;

  // Counts on the bus clock as a stand-in for both sources
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      sel_r <= 1'b0;
    end else if (stop) begin
      cnt_r <= 4'h0;
      sel_r <= sel;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        sel_r <= sel;
      end
    end else if (sel != sel_r) begin
      cnt_r <= 4'(2 * CYCLES);
    end
  end

  assign busy = (cnt_r != 4'h0) || (sel != sel_r);
  assign done = (cnt_r == 4'h1);
  assign sel_eff = sel_r;
endmodule : pllc_switch

// ### tb/pllc_monitor.sv
`timescale 1ns/10ps
module pllc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic loop_locked,
  input wire logic loop_tracking,
  input wire logic vco_clock,
  input wire logic crystal_clock,
  input wire logic pll_enable,
  input wire logic osc_enable,
  input wire logic base_clock_select,
  input wire logic base_clock_output,
  input wire logic pll_irq_req
);
  logic auto_s, ie_s, brk_s, break_clear_enable_s, wait_s, stop_s, lk_q;
  logic [3:0] stab;
  wire rdc = read && !waitrequest && address == pllc_pkg::PLLC_ADDR_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Register shadow; only the bus is visible from here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {auto_s, ie_s, brk_s, break_clear_enable_s, wait_s, stop_s} <= 6'h00;
    end else if (write && !waitrequest) begin
      case (address)
        // Enable is write-protected, not cleared, outside auto mode
        pllc_pkg::PLLC_ADDR_CTRL: if (auto_s) ie_s <= writedata[7];
        pllc_pkg::PLLC_ADDR_BW: auto_s <= writedata[7];
        pllc_pkg::PLLC_ADDR_SYS: {stop_s, wait_s, brk_s, break_clear_enable_s} <= writedata[3:0];
        default: ;
      endcase
    end
  end
  // Quiet time of the lock input, so a pending edge cannot mask a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lk_q <= 1'b0;
      stab <= 4'h0;
    end else begin
      lk_q <= loop_locked;
      if (loop_locked != lk_q) stab <= 4'h0;
      else if (stab != 4'hf) stab <= stab + 4'h1;
    end
  end
  a_ack_one_cycle: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("answer not one cycle after request");
  a_ack_short: assert property (!waitrequest && (read || write) |=> waitrequest)
    else $error("waitrequest low too long");
  a_lock_sets_flag: assert property (auto_s && ie_s && loop_locked != lk_q
    |-> ##[3:6] pll_irq_req) else $error("lock edge did not raise request");
  a_irq_needs_auto: assert property (pll_irq_req |-> $past(auto_s && ie_s))
    else $error("request without auto mode and enable");
  a_read_clears: assert property (rdc && (!brk_s || break_clear_enable_s) && stab > 4'h8
    |-> ##2 !pll_irq_req) else $error("control read left flag set");
  a_break_keeps: assert property (rdc && brk_s && !break_clear_enable_s && pll_irq_req
    |-> ##1 pll_irq_req [*2]) else $error("break read cleared flag");
  a_wait_runs: assert property (wait_s && !stop_s && !$past(stop_s, 2) |-> osc_enable)
    else $error("oscillator stopped in wait");
  a_stop_low: assert property (stop_s && $past(stop_s, 2)
    |-> !pll_enable && !osc_enable && !base_clock_output) else $error("outputs not low in stop");
  a_switch_static: assert property ($changed(base_clock_select)
    |-> $past(base_clock_output) == $past(base_clock_output, 2)) else $error("output moved");
  c_break_read: cover property (rdc && brk_s);
  c_req_rise: cover property ($rose(pll_irq_req));
  c_stop: cover property (stop_s && !osc_enable);
endmodule : pllc_monitor

bind pllc_top pllc_monitor u_pllc_monitor (.clk, .resetn, .address, .read, .write,
  .writedata, .readdata, .waitrequest, .irq, .loop_locked, .loop_tracking, .vco_clock,
  .crystal_clock, .pll_enable, .osc_enable, .base_clock_select, .base_clock_output,
  .pll_irq_req);

// ### tb/pllc_top_bench.sv
`timescale 1ns/10ps
module pllc_top_bench;
  localparam logic [3:0] ad_ctrl = pllc_pkg::PLLC_ADDR_CTRL;
  localparam logic [3:0] ad_bw = pllc_pkg::PLLC_ADDR_BW;
  localparam logic [3:0] ad_st = pllc_pkg::PLLC_ADDR_STAT;
  localparam logic [3:0] ad_mk = pllc_pkg::PLLC_ADDR_MASK;
  localparam logic [3:0] ad_sys = pllc_pkg::PLLC_ADDR_SYS;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic loop_locked = 1'b0;
  logic loop_tracking = 1'b0;
  logic vco_clock = 1'b0;
  logic crystal_clock = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, irq, pll_enable, osc_enable, base_clock_select, base_clock_output;
  logic pll_irq_req;
  logic [31:0] q[$];
  logic [31:0] exp_v;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h9848;
  pllc_top u_pllc_top (.clk, .resetn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .irq, .loop_locked, .loop_tracking, .vco_clock, .crystal_clock,
    .pll_enable, .osc_enable, .base_clock_select, .base_clock_output, .pll_irq_req);
  always #10 clk = ~clk;
  // Random source strobes, so the divided source levels are never the easy case; the switch counts on the bus clock
  always @(posedge clk) {vco_clock, crystal_clock} <= 2'($random(seed));
  task automatic stop_test;
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic fl(input string nm, input logic e, input logic g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask : fl
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      exp_v = q.pop_front();
      cmp("readdata", exp_v, readdata);
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      err_count++;
      stop_test();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic lock(input logic v);
    @(posedge clk);
    loop_locked <= v;
    wt(8);
  endtask : lock
  task automatic wsel(input logic v);
    for (int i = 0; i < 60 && base_clock_select !== v; i++) @(posedge clk);
    fl("base_clock_select", v, base_clock_select);
  endtask : wsel
  initial begin
    wt(20000);
    err_count++;
    stop_test();
  end
  initial begin
    wt(4);
    resetn <= 1'b1;
    rd(ad_ctrl, 32'h2f);
    rd(ad_bw, 32'h00);
    rd(ad_st, 32'h00);
    rd(ad_mk, 32'h00);
    rd(ad_sys, 32'h00);
    rd(4'h7, pllc_pkg::PLLC_RDATA_BAD);
    wr(ad_ctrl, 8'h00);
    wr(ad_ctrl, 8'h10);
    rd(ad_ctrl, 32'h0f);
    wr(ad_ctrl, 8'h20);
    wr(ad_ctrl, 8'h30);
    wr(ad_ctrl, 8'h10);
    rd(ad_ctrl, 32'h3f);
    wsel(1'b1);
    wr(ad_ctrl, 8'h20);
    wsel(1'b0);
    wr(ad_ctrl, 8'ha0);
    rd(ad_ctrl, 32'h2f);
    wr(ad_st, 8'h0f);
    rd(ad_st, 32'h00);
    wr(ad_mk, 8'h01);
    wr(ad_bw, 8'h80);
    wr(ad_ctrl, 8'ha0);
    lock(1'b1);
    fl("pll_irq_req", 1'b1, pll_irq_req);
    fl("irq", 1'b1, irq);
    rd(ad_bw, 32'hc0);
    rd(ad_ctrl, 32'hef);
    wt(3);
    fl("pll_irq_req", 1'b0, pll_irq_req);
    rd(ad_ctrl, 32'haf);
    wr(ad_st, 8'h01);
    wt(3);
    fl("irq", 1'b0, irq);
    loop_tracking <= 1'b1;
    wt(8);
    rd(ad_bw, 32'he0);
    rd(ad_st, 32'h04);
    wr(ad_sys, 8'h02);
    lock(1'b0);
    rd(ad_ctrl, 32'hef);
    rd(ad_ctrl, 32'hef);
    wr(ad_sys, 8'h03);
    rd(ad_ctrl, 32'hef);
    rd(ad_ctrl, 32'haf);
    wr(ad_sys, 8'h00);
    rd(ad_ctrl, 32'haf);
    rd(ad_st, 32'h06);
    wr(ad_mk, 8'h06);
    wt(3);
    fl("irq", 1'b1, irq);
    wr(ad_st, 8'h06);
    wt(3);
    fl("irq", 1'b0, irq);
    lock(1'b1);
    wr(ad_ctrl, 8'h20);
    wt(3);
    fl("pll_irq_req", 1'b0, pll_irq_req);
    wr(ad_ctrl, 8'ha0);
    wt(3);
    fl("pll_irq_req", 1'b1, pll_irq_req);
    wr(ad_bw, 8'h00);
    rd(ad_ctrl, 32'h2f);
    fl("pll_irq_req", 1'b0, pll_irq_req);
    rd(ad_bw, 32'h00);
    wr(ad_ctrl, 8'h20);
    wr(ad_sys, 8'h04);
    wt(4);
    fl("osc_enable", 1'b1, osc_enable);
    fl("pll_enable", 1'b1, pll_enable);
    wr(ad_sys, 8'h08);
    wt(4);
    fl("pll_enable", 1'b0, pll_enable);
    fl("osc_enable", 1'b0, osc_enable);
    fl("base_clock_output", 1'b0, base_clock_output);
    wr(ad_sys, 8'h00);
    stop_test();
  end
endmodule : pllc_top_bench
